//--- bench/pcsr_host.sv
`timescale 1ns/1ps
// ********************************************
// Host controller model on the register port
// ********************************************
module pcsr_host
    import pcsr_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic [7:0] reg_rdata,
    output pcsr_req_t       req
);
    initial req = '0;

    // One write strobe; data is scrambled once released so stale bytes never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk);
        #1;
        req.wr    = 1'b0;
        req.wdata = ~d;
    endtask

    // One read strobe; data is taken mid-cycle while the answer stands
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        #1;
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge sys_clk);
        #1;
        req.rd = 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask

    // Clear all four loss notifies by read-modify-write of bits 3:0
    task automatic clr_all_loss();
        logic [7:0] v;
        wr(PCSR_OFS_PAGE_SELECT, PCSR_PAGE_MONITOR);
        rd(PCSR_OFS_LOSS_STICKY, v);
        wr(PCSR_OFS_LOSS_STICKY, v | 8'h0F);
    endtask
endmodule

//--- bench/pcsr_regs_chk.sv
`timescale 1ns/1ps
// ********************************************
// Register port checker
// ********************************************
module pcsr_regs_chk
    import pcsr_pkg::*;
#(
    parameter int N_IN = 4
) (
    input  wire logic            sys_clk,
    input  wire logic            reset_n,
    input  wire pcsr_req_t       reg_req,
    input  wire logic [7:0]      reg_rdata,
    input  wire logic            reg_rvalid,
    input  wire logic [N_IN-1:0] input_loss,
    input  wire logic            nvm_programmed,
    input  wire logic            alarm_irq_n
);
    localparam int LOAD_EARLY = 1200;
    logic [7:0]  page_r;
    logic [3:0]  quiet_r;
    logic [10:0] load_r;

    // Page shadow, quiet time of the loss pins, edges since reset
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            page_r  <= PCSR_RST_PAGE;
            quiet_r <= 4'h0;
            load_r  <= 11'h000;
        end else begin
            if (reg_req.wr && reg_req.addr == PCSR_OFS_PAGE_SELECT) page_r <= reg_req.wdata;
            quiet_r <= !$stable(input_loss) ? 4'h0 : (quiet_r == 4'hF) ? quiet_r : quiet_r + 4'h1;
            if (load_r != 11'h7FF) load_r <= load_r + 11'h001;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence s_page_set;
        reg_req.wr && reg_req.addr == PCSR_OFS_PAGE_SELECT;
    endsequence
    sequence s_page_get;
        !reg_req.wr ##1 reg_req.rd && reg_req.addr == PCSR_OFS_PAGE_SELECT;
    endsequence
    // Quiet pins matter: a late rising edge may legally set a notify again
    sequence s_clear_all;
        reg_req.wr && page_r == PCSR_PAGE_MONITOR && reg_req.addr == PCSR_OFS_LOSS_STICKY
            && reg_req.wdata[3:0] == 4'hF && quiet_r > 4'h8;
    endsequence

    a_page_readback: assert property (s_page_set ##1 s_page_get |=> reg_rdata == $past(reg_req.wdata, 3))
        else $error("page select readback wrong");
    // Back-to-back reads are legal, so each answer must follow its own strobe
    a_rvalid_timing: assert property (reg_rvalid == $past(reg_req.rd))
        else $error("read answer not one cycle late");
    a_rdata_holds: assert property (!reg_rvalid |-> $stable(reg_rdata))
        else $error("read data moved without answer");
    a_live_flags: assert property (reg_req.rd && page_r == PCSR_PAGE_MONITOR && reg_req.addr == PCSR_OFS_LOSS_LIVE
        && quiet_r > 4'h5 |=> reg_rdata == 8'($past(input_loss)))
        else $error("live loss flags wrong");
    a_clear_all: assert property (s_clear_all |-> ##[1:3] alarm_irq_n)
        else $error("alarm stays low after clearing");
    a_alarm_no_fall: assert property (quiet_r > 4'h8 && alarm_irq_n |=> alarm_irq_n)
        else $error("alarm fell without rising loss");
    a_idle_load: assert property (reg_req.rd && page_r == PCSR_PAGE_MASTER
        && reg_req.addr == PCSR_OFS_STATE_READBACK && load_r < LOAD_EARLY |=> reg_rdata == PCSR_CODE_IDLE)
        else $error("master left idle during load");
    a_pll_zero: assert property (reg_req.rd && page_r >= PCSR_PAGE_PLL_A && page_r <= PCSR_PAGE_PLL_D
        && reg_req.addr != PCSR_OFS_PAGE_SELECT |=> reg_rdata == 8'h00)
        else $error("pll page read not zero");
endmodule

//--- bench/tb_paged_config_status_regs.sv
`timescale 1ns/1ps
module tb_paged_config_status_regs
    import pcsr_pkg::*;
;
    localparam logic [7:0] PG [4] = '{PCSR_PAGE_MASTER, PCSR_PAGE_INPUT, PCSR_PAGE_MONITOR, PCSR_PAGE_OUTPUT};
    localparam logic [7:0] SL [4] = '{PCSR_SEL_MASTER, PCSR_SEL_INPUT, PCSR_SEL_MONITOR, PCSR_SEL_OUTPUT};
    localparam logic [7:0] MK [4] = '{8'hFF, 8'h1F, 8'h0F, 8'h1F};
    localparam logic [7:0] WT [4] = '{PCSR_CODE_MASTER_WAIT, PCSR_CODE_IN_WAIT, PCSR_CODE_MON_WAIT, PCSR_CODE_OUT_WAIT};
    localparam logic [7:0] AC [4] = '{PCSR_CODE_MASTER_ACT, PCSR_CODE_IN_ACT, PCSR_CODE_MON_ACT, PCSR_CODE_OUT_ACT};
    logic       sys_clk;
    logic       reset_n;
    pcsr_req_t  reg_req;
    logic [7:0] reg_rdata;
    logic       reg_rvalid;
    logic [3:0] input_loss;
    logic       nvm_programmed;
    logic       alarm_irq_n;
    int         fails;
    int         num_checks;
    integer     seed;
    logic [7:0] exp_q[$];
    logic [7:0] msk_q[$];
    logic [3:0] notify_exp;
    logic [3:0] pins;
    logic [3:0] mask_exp;
    logic [3:0] sel_exp;
    logic [7:0] d;

    pcsr_regs #(.N_IN(4)) DUT (.sys_clk(sys_clk), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .input_loss(input_loss), .nvm_programmed(nvm_programmed), .alarm_irq_n(alarm_irq_n));
    pcsr_host host (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .req(reg_req));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic cmp8(input string what, input logic [7:0] e, input logic [7:0] s);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", what, e, s);
        end
    endtask
    task automatic cmp1(input string what, input logic e, input logic s);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("BAD %s exp %b got %b", what, e, s);
        end
    endtask
    task automatic note(input logic [7:0] e, input logic [7:0] m);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
    endtask
    // Expected value is queued before the strobe so the monitor never runs ahead
    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
        logic [7:0] v;
        note(e, m);
        host.rd(a, v);
    endtask
    task automatic rst(input logic strap);
        @(posedge sys_clk);
        #1;
        reset_n = 1'b0;
        nvm_programmed = strap;
        repeat (2) @(posedge sys_clk);
        #1;
        reset_n = 1'b1;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Read answers are compared mid-cycle against the oldest note
    always @(negedge sys_clk) begin
        logic [7:0] e;
        logic [7:0] m;
        if (reg_rvalid === 1'b1) begin
            if (exp_q.size() == 0) cmp8("unexpected answer", 8'h00, 8'hFF);
            else begin
                e = exp_q.pop_front();
                m = msk_q.pop_front();
                cmp8("reg_rdata", e, reg_rdata & m);
            end
        end
    end

    // Hang guard
    initial begin
        #200000;
        cmp8("run time", 8'h00, 8'hFF);
        tally_and_finish();
    end

    initial begin
        reset_n = 1'b0;
        input_loss = 4'h0;
        nvm_programmed = 1'b0;
        seed = 32'hfc0834ed;
        notify_exp = PCSR_RST_NOTIFY;
        rst(1'b0);
        rdc(PCSR_OFS_PAGE_SELECT, PCSR_RST_PAGE);
        cmp1("alarm_irq_n", 1'b0, alarm_irq_n);
        host.wr(PCSR_OFS_STATE_SELECT, PCSR_SEL_MASTER);
        rdc(PCSR_OFS_STATE_READBACK, PCSR_CODE_IDLE);
        repeat (PCSR_NVM_LOAD_CYCLES + 4) @(posedge sys_clk);
        $display("test idle during load done");
        // Inputs are engaged, so pages 2 and 1 are not skipped; no PLL page is used
        for (int i = 0; i < 4; i++) begin
            host.wr(PCSR_OFS_PAGE_SELECT, PG[i]);
            host.wr(PCSR_OFS_STATE_SELECT, SL[i]);
            rdc(PCSR_OFS_STATE_READBACK, WT[i], MK[i]);
            host.wr(PCSR_OFS_COMMIT, PCSR_COMMIT_GO);
            rdc(PCSR_OFS_STATE_READBACK, AC[i], MK[i]);
            host.wr(PCSR_OFS_STATE_SELECT, SL[i] ^ 8'h20);
            rdc(PCSR_OFS_STATE_SELECT, SL[i] ^ 8'h20);
            rdc(PCSR_OFS_STATE_READBACK, PCSR_CODE_IDLE);
        end
        $display("test state readback done");
        // Every documented page plus one random value
        for (int i = 0; i < 9; i++) begin
            d = (i < 4) ? 8'(i) : (i < 8) ? 8'(PCSR_PAGE_PLL_A + i - 4) : 8'($random(seed));
            host.wr(PCSR_OFS_PAGE_SELECT, d);
            rdc(PCSR_OFS_PAGE_SELECT, d);
            rdc(PCSR_OFS_STATE_READBACK, PCSR_CODE_IDLE);
        end
        $display("test page select done");
        note({4'h0, notify_exp}, 8'hFF);
        host.clr_all_loss();
        // Alarm selection changed only while no notify is set
        sel_exp = 4'($random(seed));
        host.wr(PCSR_OFS_ALARM_SELECT, {4'h0, sel_exp});
        rdc(PCSR_OFS_ALARM_SELECT, {4'h0, sel_exp});
        notify_exp = 4'h0;
        pins = 4'h0;
        // Random loss patterns under random masks; only rising edges set notifies
        for (int i = 0; i < 16; i++) begin
            mask_exp = 4'($random(seed));
            host.wr(PCSR_OFS_LOSS_MASK, {4'h0, mask_exp});
            rdc(PCSR_OFS_LOSS_MASK, {4'h0, mask_exp});
            d = 8'($random(seed));
            notify_exp = notify_exp | (d[3:0] & ~pins & mask_exp);
            pins = d[3:0];
            @(posedge sys_clk);
            #1;
            input_loss = pins;
            repeat (8) @(posedge sys_clk);
            rdc(PCSR_OFS_LOSS_LIVE, {4'h0, pins});
            rdc(PCSR_OFS_LOSS_STICKY, {4'h0, notify_exp});
            d = 8'($random(seed));
            host.wr(PCSR_OFS_LOSS_STICKY, d);
            notify_exp = notify_exp & ~d[3:0];
            rdc(PCSR_OFS_LOSS_STICKY, {4'h0, notify_exp});
            repeat (3) @(negedge sys_clk);
            cmp1("alarm_irq_n", (notify_exp & sel_exp) == 4'h0, alarm_irq_n);
        end
        $display("test loss notify done");
        // A programmed part wakes up without host commits
        rst(1'b1);
        repeat (PCSR_NVM_LOAD_CYCLES + 4) @(posedge sys_clk);
        host.wr(PCSR_OFS_STATE_SELECT, PCSR_SEL_MASTER);
        rdc(PCSR_OFS_STATE_READBACK, PCSR_CODE_MASTER_ACT);
        host.wr(PCSR_OFS_PAGE_SELECT, PCSR_PAGE_OUTPUT);
        host.wr(PCSR_OFS_STATE_SELECT, PCSR_SEL_OUTPUT);
        rdc(PCSR_OFS_STATE_READBACK, PCSR_CODE_OUT_ACT, 8'h1F);
        repeat (4) @(posedge sys_clk);
        if (exp_q.size() != 0) cmp8("missing answers", 8'h00, 8'(exp_q.size()));
        $display("test wake up done");
        tally_and_finish();
    end
endmodule

bind pcsr_regs pcsr_regs_chk #(.N_IN(N_IN)) u_chk (.sys_clk(sys_clk), .reset_n(reset_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .input_loss(input_loss), .nvm_programmed(nvm_programmed),
    .alarm_irq_n(alarm_irq_n));

//--- include/pcsr_pkg.sv
// ***************************************************************
// Paged configuration and status register constants
// ***************************************************************
package pcsr_pkg;

    // ***************************************************************
    // Register offsets within a page
    // ***************************************************************
    localparam logic [7:0] PCSR_OFS_PAGE_SELECT     = 8'hFF;
    localparam logic [7:0] PCSR_OFS_LOSS_LIVE       = 8'h02;
    localparam logic [7:0] PCSR_OFS_LOSS_STICKY     = 8'h03;
    localparam logic [7:0] PCSR_OFS_LOSS_MASK       = 8'h04;
    localparam logic [7:0] PCSR_OFS_ALARM_SELECT    = 8'h05;
    localparam logic [7:0] PCSR_OFS_COMMIT          = 8'h0E;
    localparam logic [7:0] PCSR_OFS_STATE_READBACK  = 8'hD0;
    localparam logic [7:0] PCSR_OFS_STATE_SELECT    = 8'hD1;

    // ***************************************************************
    // Page numbers
    // ***************************************************************
    localparam logic [7:0] PCSR_PAGE_MASTER  = 8'h00;
    localparam logic [7:0] PCSR_PAGE_MONITOR = 8'h01;
    localparam logic [7:0] PCSR_PAGE_INPUT   = 8'h02;
    localparam logic [7:0] PCSR_PAGE_OUTPUT  = 8'h03;
    localparam logic [7:0] PCSR_PAGE_PLL_A   = 8'h0A;
    localparam logic [7:0] PCSR_PAGE_PLL_D   = 8'h0D;

    // ***************************************************************
    // Reset values and field values
    // ***************************************************************
    localparam logic [7:0] PCSR_RST_PAGE         = 8'h00;
    localparam logic [7:0] PCSR_RST_MASK         = 8'hFF;
    localparam logic [3:0] PCSR_RST_NOTIFY       = 4'hF;
    localparam logic [3:0] PCSR_RST_ALARM_SELECT = 4'hF;
    localparam logic [7:0] PCSR_RST_SELECT       = 8'h00;
    localparam logic [7:0] PCSR_COMMIT_GO        = 8'h01;

    // State readback selectors and codes per subsystem
    localparam logic [7:0] PCSR_SEL_MASTER  = 8'h40;
    localparam logic [7:0] PCSR_SEL_MONITOR = 8'h40;
    localparam logic [7:0] PCSR_SEL_INPUT   = 8'h40;
    localparam logic [7:0] PCSR_SEL_OUTPUT  = 8'h60;
    localparam logic [7:0] PCSR_CODE_IDLE        = 8'h00;
    localparam logic [7:0] PCSR_CODE_MASTER_WAIT = 8'h09;
    localparam logic [7:0] PCSR_CODE_MASTER_ACT  = 8'h24;
    localparam logic [7:0] PCSR_CODE_MON_WAIT    = 8'h05;
    localparam logic [7:0] PCSR_CODE_MON_ACT     = 8'h0C;
    localparam logic [7:0] PCSR_CODE_IN_WAIT     = 8'h07;
    localparam logic [7:0] PCSR_CODE_IN_ACT      = 8'h17;
    localparam logic [7:0] PCSR_CODE_OUT_WAIT    = 8'h0C;
    localparam logic [7:0] PCSR_CODE_OUT_ACT     = 8'h14;

    // ***************************************************************
    // Timing
    // ***************************************************************
    localparam int PCSR_CLK_MHZ         = 125;
    localparam int PCSR_NVM_LOAD_NS     = 10000;
    localparam int PCSR_NVM_LOAD_CYCLES = (PCSR_NVM_LOAD_NS * PCSR_CLK_MHZ + 999) / 1000;

    // ***************************************************************
    // Types
    // ***************************************************************
    typedef enum logic [1:0] {
        PCSR_ST_IDLE,
        PCSR_ST_PRG_WAIT,
        PCSR_ST_ACTIVE
    } pcsr_state_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pcsr_req_t;

endpackage

//--- verilog/pcsr_loss_notify.sv
`timescale 1ns/1ps
// ***************************************************************
// Loss pin synchroniser, live status and sticky notify
// ***************************************************************
module pcsr_loss_notify
    import pcsr_pkg::*;
#(
    parameter int N = 4
) (
    input  wire logic         sys_clk,
    input  wire logic         reset_n,
    input  wire logic [N-1:0] loss_pin,
    input  wire logic [N-1:0] mask,
    input  wire logic         clr_wr,
    input  wire logic [N-1:0] clr_bits,
    output logic      [N-1:0] live,
    output logic      [N-1:0] notify
);

    logic [N-1:0] sync1_r;
    logic [N-1:0] sync2_r;
    logic [N-1:0] sync3_r;
    logic [N-1:0] live_r;
    logic [N-1:0] notify_r;
    logic [N-1:0] rise;

    // Three stages; first stage feeds only the second
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
        end else begin
            sync1_r <= loss_pin;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // Live level changes only when stages two and three agree
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            live_r <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                if (sync2_r[i] == sync3_r[i]) begin
                    live_r[i] <= sync3_r[i];
                end
            end
        end
    end

    assign rise = (sync2_r & sync3_r) & ~live_r;

    // Set beats clear so a loss in the clearing cycle is kept
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            notify_r <= PCSR_RST_NOTIFY[N-1:0];
        end else begin
            for (int i = 0; i < N; i++) begin
                if (rise[i] && mask[i]) begin
                    notify_r[i] <= 1'b1;
                end else if (clr_wr && clr_bits[i]) begin
                    notify_r[i] <= 1'b0;
                end
            end
        end
    end

    assign live   = live_r;
    assign notify = notify_r;

endmodule

//--- verilog/pcsr_regs.sv
`timescale 1ns/1ps
module pcsr_regs
    import pcsr_pkg::*;
#(
    parameter int N_IN = 4
) (
    input  wire logic            sys_clk,
    input  wire logic            reset_n,
    input  wire pcsr_req_t       reg_req,
    output logic      [7:0]      reg_rdata,
    output logic                 reg_rvalid,
    input  wire logic [N_IN-1:0] input_loss,
    input  wire logic            nvm_programmed,
    output logic                 alarm_irq_n
);

    // ***************************************************************
    // Helpers
    // ***************************************************************

    // Readback code for a subsystem in a given state
    function automatic logic [7:0] state_code(input logic [1:0] sub, input pcsr_state_t st);
        logic [7:0] wait_c;
        logic [7:0] act_c;
        wait_c = PCSR_CODE_MASTER_WAIT;
        act_c  = PCSR_CODE_MASTER_ACT;
        unique case (sub)
            2'h0: begin
                wait_c = PCSR_CODE_MASTER_WAIT;
                act_c  = PCSR_CODE_MASTER_ACT;
            end
            2'h1: begin
                wait_c = PCSR_CODE_MON_WAIT;
                act_c  = PCSR_CODE_MON_ACT;
            end
            2'h2: begin
                wait_c = PCSR_CODE_IN_WAIT;
                act_c  = PCSR_CODE_IN_ACT;
            end
            2'h3: begin
                wait_c = PCSR_CODE_OUT_WAIT;
                act_c  = PCSR_CODE_OUT_ACT;
            end
        endcase
        unique case (st)
            PCSR_ST_IDLE:     state_code = PCSR_CODE_IDLE;
            PCSR_ST_PRG_WAIT: state_code = wait_c;
            PCSR_ST_ACTIVE:   state_code = act_c;
            default:          state_code = PCSR_CODE_IDLE;
        endcase
    endfunction

    // Selector value that enables readback on a subsystem page
    function automatic logic [7:0] state_sel(input logic [1:0] sub);
        unique case (sub)
            2'h0:    state_sel = PCSR_SEL_MASTER;
            2'h1:    state_sel = PCSR_SEL_MONITOR;
            2'h2:    state_sel = PCSR_SEL_INPUT;
            default: state_sel = PCSR_SEL_OUTPUT;
        endcase
    endfunction

    // ***************************************************************
    // Declarations
    // ***************************************************************
    logic [7:0]      page_r;
    logic [7:0]      mask_r;
    logic [N_IN-1:0] alarm_sel_r;
    logic [7:0]      sel_r [4];
    pcsr_state_t     st_r  [4];
    logic [$clog2(PCSR_NVM_LOAD_CYCLES+1)-1:0] load_cnt_r;
    logic            load_done_r;
    logic            strap_r;
    logic [7:0]      rdata_r;
    logic            rvalid_r;
    logic            irq_n_r;
    logic [N_IN-1:0] live;
    logic [N_IN-1:0] notify;
    logic            sub_page;
    logic [1:0]      sub_idx;
    logic            wr_here;

    assign sub_page = (page_r[7:2] == 6'h00);
    assign sub_idx  = page_r[1:0];
    assign wr_here  = reg_req.wr && sub_page;

    // ***************************************************************
    // Page select
    // ***************************************************************

    // All later accesses steer by this value
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            page_r <= PCSR_RST_PAGE;
        end else if (reg_req.wr && reg_req.addr == PCSR_OFS_PAGE_SELECT) begin
            page_r <= reg_req.wdata;
        end
    end

    // ***************************************************************
    // Monitor page: mask, alarm select, notify logic
    // ***************************************************************

    // Mask and alarm selection on the monitor page
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mask_r      <= PCSR_RST_MASK;
            alarm_sel_r <= PCSR_RST_ALARM_SELECT[N_IN-1:0];
        end else if (reg_req.wr && page_r == PCSR_PAGE_MONITOR) begin
            if (reg_req.addr == PCSR_OFS_LOSS_MASK) begin
                mask_r <= reg_req.wdata;
            end
            if (reg_req.addr == PCSR_OFS_ALARM_SELECT) begin
                alarm_sel_r <= reg_req.wdata[N_IN-1:0];
            end
        end
    end

    // Runs on the same clock as the register file
    pcsr_loss_notify #(
        .N(N_IN)
    ) u_notify (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .loss_pin (input_loss),
        .mask     (mask_r[N_IN-1:0]),
        .clr_wr   (reg_req.wr && page_r == PCSR_PAGE_MONITOR && reg_req.addr == PCSR_OFS_LOSS_STICKY),
        .clr_bits (reg_req.wdata[N_IN-1:0]),
        .live     (live),
        .notify   (notify)
    );

    // Low while any selected notify is set; registered output
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_n_r <= 1'b1;
        end else begin
            irq_n_r <= ~|(notify & alarm_sel_r);
        end
    end

    // ***************************************************************
    // Nonvolatile load timer and strap capture
    // ***************************************************************

    // Strap sampled once the load time has run out
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            load_cnt_r  <= '0;
            load_done_r <= 1'b0;
            strap_r     <= 1'b0;
        end else if (!load_done_r) begin
            if (load_cnt_r == ($bits(load_cnt_r))'(PCSR_NVM_LOAD_CYCLES - 1)) begin
                load_done_r <= 1'b1;
                strap_r     <= nvm_programmed;
            end else begin
                load_cnt_r <= load_cnt_r + 1'b1;
            end
        end
    end

    // ***************************************************************
    // Subsystem state machines and readback selectors
    // ***************************************************************

    // Master leaves idle after load; slaves follow it out of idle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 4; i++) begin
                st_r[i] <= PCSR_ST_IDLE;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                unique case (st_r[i])
                    PCSR_ST_IDLE: begin
                        if (i == 0 && load_done_r) begin
                            // Programmed part wakes alone; blank part waits
                            st_r[i] <= strap_r ? PCSR_ST_ACTIVE : PCSR_ST_PRG_WAIT;
                        end else if (i != 0 && st_r[0] != PCSR_ST_IDLE) begin
                            st_r[i] <= strap_r ? PCSR_ST_ACTIVE : PCSR_ST_PRG_WAIT;
                        end
                    end
                    PCSR_ST_PRG_WAIT: begin
                        if (wr_here && sub_idx == 2'(i) && reg_req.addr == PCSR_OFS_COMMIT
                            && reg_req.wdata == PCSR_COMMIT_GO) begin
                            st_r[i] <= PCSR_ST_ACTIVE;
                        end
                    end
                    PCSR_ST_ACTIVE: begin
                        st_r[i] <= PCSR_ST_ACTIVE;
                    end
                endcase
            end
        end
    end

    // One selector per subsystem page
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 4; i++) begin
                sel_r[i] <= PCSR_RST_SELECT;
            end
        end else if (wr_here && reg_req.addr == PCSR_OFS_STATE_SELECT) begin
            sel_r[sub_idx] <= reg_req.wdata;
        end
    end

    // ***************************************************************
    // Read path, one cycle after the strobe
    // ***************************************************************

    // Unmapped offsets and PLL pages read zero, apart from the page select offset, which reads back on every page
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= reg_req.rd;
            if (reg_req.rd) begin
                rdata_r <= 8'h00;
                if (reg_req.addr == PCSR_OFS_PAGE_SELECT) begin
                    rdata_r <= page_r;
                end else if (sub_page && reg_req.addr == PCSR_OFS_STATE_SELECT) begin
                    rdata_r <= sel_r[sub_idx];
                end else if (sub_page && reg_req.addr == PCSR_OFS_STATE_READBACK) begin
                    if (sel_r[sub_idx] == state_sel(sub_idx)) begin
                        rdata_r <= state_code(sub_idx, st_r[sub_idx]);
                    end
                end else if (page_r == PCSR_PAGE_MONITOR) begin
                    unique case (reg_req.addr)
                        PCSR_OFS_LOSS_LIVE:    rdata_r <= 8'(live);
                        PCSR_OFS_LOSS_STICKY:  rdata_r <= 8'(notify);
                        PCSR_OFS_LOSS_MASK:    rdata_r <= mask_r;
                        PCSR_OFS_ALARM_SELECT: rdata_r <= 8'(alarm_sel_r);
                        default:               rdata_r <= 8'h00;
                    endcase
                end
            end
        end
    end

    assign reg_rdata   = rdata_r;
    assign reg_rvalid  = rvalid_r;
    assign alarm_irq_n = irq_n_r;

endmodule
